// file: hw/isp_pkg.sv
package isp_pkg;

  // Register byte addresses.
  localparam logic [15:0] ADDR_SENSE_MODE_SECOND = 16'hf608;
  localparam logic [15:0] ADDR_PRIORITY_LEVEL_FIRST = 16'hf610;
  localparam logic [15:0] ADDR_EVENT_STATUS = 16'hf640;
  localparam logic [15:0] ADDR_EVENT_MASK = 16'hf644;

  // Sense-mode field positions (low bit of each 2-bit field).
  localparam int POS_AUDIO_POWER_EVENT = 18;
  localparam int POS_AUDIO_LINK = 16;
  localparam int POS_PERIPHERAL_DMA = 14;
  localparam int POS_SOURCE_FOURTEEN = 12;
  localparam int POS_DMA_CH3 = 10;
  localparam int POS_DMA_CH2 = 8;
  localparam int POS_DMA_CH1 = 6;
  localparam int POS_DMA_CH0 = 4;
  localparam int POS_SERIAL_PORT1 = 2;
  localparam int POS_SERIAL_PORT0 = 0;

  // Priority field positions (low bit of each 3-bit field).
  localparam int POS_TIMER0 = 24;
  localparam int POS_PCI_CONTROLLER = 16;
  localparam int POS_WRITE_TIMEOUT = 8;
  localparam int POS_MEMORY_ECC_ERROR = 0;

  // Writable bit masks and reset values.
  localparam logic [31:0] MASK_SENSE_MODE_SECOND = 32'h000f_fff0 | 32'h0000_000f;
  localparam logic [31:0] MASK_PRIORITY_LEVEL_FIRST = 32'h0707_0707;
  localparam logic [31:0] RESET_SENSE_MODE_SECOND = 32'h0000_0000;
  localparam logic [31:0] RESET_PRIORITY_LEVEL_FIRST = 32'h0000_0000;
  localparam logic [1:0] SENSE_LOW_ACTIVE = 2'h0;
  localparam logic [2:0] LEVEL_DISABLED = 3'h0;

  localparam int NUM_SENSE = 10;
  localparam int NUM_LEVEL = 4;
  localparam logic [NUM_SENSE-1:0] EVENT_RESET = 10'h000;

  typedef enum logic [1:0] {
    ISP_HTRANS_IDLE = 2'h0,
    ISP_HTRANS_BUSY = 2'h1,
    ISP_HTRANS_NONSEQ = 2'h2,
    ISP_HTRANS_SEQ = 2'h3
  } isp_htrans_type;

  typedef struct packed {
    logic sel;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic [31:0] addr;
  } isp_addr_phase_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
  } isp_pending_type;

  typedef struct packed {
    logic [NUM_LEVEL-1:0] request;
    logic [NUM_LEVEL*3-1:0] level;
  } isp_level_req_type;

endpackage

// file: hw/isp_regs.sv
`timescale 1ns/1ps
module isp_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Raw source request lines, active low.
  input wire logic [isp_pkg::NUM_SENSE-1:0] senseRequestN,
  input wire logic [isp_pkg::NUM_LEVEL-1:0] levelRequestN,
  // Qualified requests toward the core.
  output logic [isp_pkg::NUM_SENSE-1:0] sensePending,
  output isp_pkg::isp_level_req_type levelPending,
  // Interrupt.
  output logic irq
);
  import isp_pkg::*;

  logic [31:0] senseMode;
  logic [31:0] priorityLevel;
  logic [NUM_SENSE-1:0] eventStatus;
  logic [NUM_SENSE-1:0] eventMask;
  isp_pending_type pending;
  logic [31:0] next_senseMode;
  logic [31:0] next_priorityLevel;
  logic [NUM_SENSE-1:0] next_eventStatus;
  logic [NUM_SENSE-1:0] next_eventMask;
  isp_pending_type next_pending;
  logic [NUM_SENSE-1:0] next_sensePending;
  isp_level_req_type next_levelPending;
  logic [31:0] next_hrdata;
  logic [NUM_SENSE-1:0] senseEnable;
  logic [NUM_SENSE-1:0] senseRise;

  // Returns the low bit of sense field i, in register order from serial port 0.
  function automatic int sensePos(input int i);
    case (i)
      0: sensePos = POS_SERIAL_PORT0;
      1: sensePos = POS_SERIAL_PORT1;
      2: sensePos = POS_DMA_CH0;
      3: sensePos = POS_DMA_CH1;
      4: sensePos = POS_DMA_CH2;
      5: sensePos = POS_DMA_CH3;
      6: sensePos = POS_SOURCE_FOURTEEN;
      7: sensePos = POS_PERIPHERAL_DMA;
      8: sensePos = POS_AUDIO_LINK;
      default: sensePos = POS_AUDIO_POWER_EVENT;
    endcase
  endfunction

  // Returns the low bit of priority field i: ECC, write timeout, PCI, timer 0.
  function automatic int levelPos(input int i);
    case (i)
      0: levelPos = POS_MEMORY_ECC_ERROR;
      1: levelPos = POS_WRITE_TIMEOUT;
      2: levelPos = POS_PCI_CONTROLLER;
      default: levelPos = POS_TIMER0;
    endcase
  endfunction

  // Bus never stalls and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(eventStatus & eventMask);

  always_comb begin
    for (int i = 0; i < NUM_SENSE; i++) begin
      senseEnable[i] = (senseMode[sensePos(i) +: 2] == SENSE_LOW_ACTIVE);
      next_sensePending[i] = senseEnable[i] & ~senseRequestN[i];
    end
    for (int j = 0; j < NUM_LEVEL; j++) begin
      next_levelPending.level[j*3 +: 3] = priorityLevel[levelPos(j) +: 3];
      next_levelPending.request[j] = (priorityLevel[levelPos(j) +: 3] != LEVEL_DISABLED)
        & ~levelRequestN[j];
    end
    senseRise = next_sensePending & ~sensePending;
  end

  always_comb begin
    next_pending = pending;
    next_senseMode = senseMode;
    next_priorityLevel = priorityLevel;
    next_eventMask = eventMask;
    next_eventStatus = eventStatus;
    next_hrdata = hrdata;
    if (pending.valid && pending.write) begin
      case (pending.addr)
        ADDR_SENSE_MODE_SECOND: next_senseMode = hwdata & MASK_SENSE_MODE_SECOND;
        ADDR_PRIORITY_LEVEL_FIRST: next_priorityLevel = hwdata & MASK_PRIORITY_LEVEL_FIRST;
        ADDR_EVENT_MASK: next_eventMask = hwdata[NUM_SENSE-1:0];
        ADDR_EVENT_STATUS: next_eventStatus = eventStatus & ~hwdata[NUM_SENSE-1:0];
        default: next_eventMask = eventMask;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    next_eventStatus = next_eventStatus | senseRise;
    next_pending.valid = 1'b0;
    if (hready && hsel && htrans[1]) begin
      next_pending.valid = 1'b1;
      next_pending.write = hwrite;
      next_pending.addr = haddr[15:0];
      if (!hwrite) begin
        case (haddr[15:0])
          ADDR_SENSE_MODE_SECOND: next_hrdata = senseMode;
          ADDR_PRIORITY_LEVEL_FIRST: next_hrdata = priorityLevel;
          ADDR_EVENT_STATUS: next_hrdata = {22'h00_0000, eventStatus};
          ADDR_EVENT_MASK: next_hrdata = {22'h00_0000, eventMask};
          default: next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      senseMode <= RESET_SENSE_MODE_SECOND;
      priorityLevel <= RESET_PRIORITY_LEVEL_FIRST;
      eventStatus <= EVENT_RESET;
      eventMask <= EVENT_RESET;
      pending <= '0;
      hrdata <= 32'h0000_0000;
      sensePending <= '0;
      levelPending <= '0;
    end else begin
      senseMode <= next_senseMode;
      priorityLevel <= next_priorityLevel;
      eventStatus <= next_eventStatus;
      eventMask <= next_eventMask;
      pending <= next_pending;
      hrdata <= next_hrdata;
      sensePending <= next_sensePending;
      levelPending <= next_levelPending;
    end
  end

endmodule

// file: tb/isp_src_model.sv
`timescale 1ns/1ps
module isp_src_model (
  // Clock and request controls.
  input wire logic clk,
  input wire logic [isp_pkg::NUM_SENSE-1:0] srcOn,
  input wire logic [isp_pkg::NUM_LEVEL-1:0] lvlOn,
  // Active-low request lines.
  output logic [isp_pkg::NUM_SENSE-1:0] senseRequestN = '1,
  output logic [isp_pkg::NUM_LEVEL-1:0] levelRequestN = '1
);
  always @(posedge clk) begin
    senseRequestN <= ~srcOn;
    levelRequestN <= ~lvlOn;
  end
endmodule

// file: tb/isp_regs_chk.sv
`timescale 1ns/1ps
module isp_regs_chk (
  input wire logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq,
  input wire logic [31:0] haddr, hrdata,
  input wire logic [1:0] htrans,
  input wire logic [isp_pkg::NUM_SENSE-1:0] senseRequestN, sensePending,
  input wire logic [isp_pkg::NUM_LEVEL-1:0] levelRequestN,
  input wire isp_pkg::isp_level_req_type levelPending
);
  import isp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rdTake = hsel && hready && htrans[1] && !hwrite;
  property p_rdy; hreadyout; endproperty
  property p_ok; !hresp; endproperty
  property p_rst; $past(rst) |-> hrdata == 0 && !irq && sensePending == 0 && levelPending == 0; endproperty
  property p_hold; !$past(rdTake) |-> $stable(hrdata); endproperty
  property p_unm; rdTake && haddr[15:0] == 16'h0000 |=> hrdata == 0; endproperty
  property p_sp; (sensePending & $past(senseRequestN)) == 0; endproperty
  property p_lp; (levelPending.request & $past(levelRequestN)) == 0; endproperty
  property p_lz; levelPending.request[0] |-> levelPending.level[2:0] != 0; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state seen");
  a_ok: assert property (p_ok) else $error("error response");
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
  a_sp: assert property (p_sp) else $error("pending without request");
  a_lp: assert property (p_lp) else $error("level pending without request");
  a_lz: assert property (p_lz) else $error("level zero pending");
  c_sp: cover property (sensePending[9]);
  c_lp: cover property (levelPending.request == 4'hf);
  c_irq: cover property (irq);
endmodule
bind isp_regs isp_regs_chk u_chk (.*);

// file: tb/isp_regs_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("mismatch %0t %h", $time, (a)); end end
module isp_regs_tb;
  import isp_pkg::*;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [9:0] srcOn = 0, senseRequestN, sensePending;
  logic [3:0] lvlOn = 0, levelRequestN;
  isp_level_req_type levelPending;
  int checked = 0, failures = 0;
  always #4 clk = ~clk;
  isp_src_model u_src (.clk(clk), .srcOn(srcOn), .lvlOn(lvlOn), .senseRequestN(senseRequestN),
    .levelRequestN(levelRequestN));
  isp_regs DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .senseRequestN(senseRequestN), .levelRequestN(levelRequestN),
    .sensePending(sensePending), .levelPending(levelPending), .irq(irq));
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic step();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        failures++;
        report_and_stop();
      end
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d);
    hsel <= 1;
    htrans <= ISP_HTRANS_NONSEQ;
    haddr <= {16'h0000, a};
    hwrite <= w;
    step();
    hsel <= 0;
    htrans <= ISP_HTRANS_IDLE;
    hwdata <= d;
    step();
    q = hrdata;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    bus(ADDR_SENSE_MODE_SECOND, 0, 0); `CHK(q, 32'h0000_0000)
    bus(ADDR_PRIORITY_LEVEL_FIRST, 0, 0); `CHK(q, 32'h0000_0000)
    bus(ADDR_SENSE_MODE_SECOND, 1, '1);
    bus(ADDR_SENSE_MODE_SECOND, 0, 0); `CHK(q, 32'h000f_ffff)
    bus(ADDR_PRIORITY_LEVEL_FIRST, 1, '1);
    bus(ADDR_PRIORITY_LEVEL_FIRST, 0, 0); `CHK(q, 32'h0707_0707)
    srcOn <= '1;
    lvlOn <= '1;
    repeat (3) @(posedge clk);
    `CHK(sensePending, 10'h000)
    `CHK(levelPending.request, 4'hf)
    for (int i = 0; i < 10; i++) begin
      bus(ADDR_SENSE_MODE_SECOND, 1, {16{2'(i % 3 + 1)}} & ~(32'h3 << 2 * i));
      repeat (2) @(posedge clk);
      `CHK(sensePending, 10'h1 << i)
    end
    for (int j = 0; j < 4; j++) begin
      bus(ADDR_PRIORITY_LEVEL_FIRST, 1, 32'(j + 1) << 8 * j);
      repeat (2) @(posedge clk);
      `CHK(levelPending, {4'h1 << j, 12'(j + 1) << 3 * j})
    end
    bus(ADDR_EVENT_STATUS, 0, 0); `CHK(q, 32'h0000_03ff)
    `CHK(irq, 1'b0)
    bus(ADDR_EVENT_MASK, 1, 32'h0000_0200);
    @(posedge clk); `CHK(irq, 1'b1)
    bus(ADDR_EVENT_STATUS, 1, '1);
    @(posedge clk); `CHK(irq, 1'b0)
    bus(16'h0000, 1, '1);
    bus(16'h0000, 0, 0); `CHK(q, 32'h0000_0000)
    report_and_stop();
  end
endmodule
